//--- hw/acc_pkg.sv
// package for the analog comparator control block
package acc_pkg;

  // ==========================================================================
  // register map: indices, the byte address is four times the index
  localparam logic [7:0]  ACC_IDX_CTRL    = 8'h18;
  localparam logic [7:0]  ACC_IDX_REFSEL  = 8'h19;
  localparam logic [7:0]  ACC_IDX_IRQST   = 8'h1A;
  localparam logic [7:0]  ACC_IDX_IRQMSK  = 8'h1B;
  localparam logic [9:0]  ACC_ADDR_CTRL   = {ACC_IDX_CTRL, 2'h0};
  localparam logic [9:0]  ACC_ADDR_REFSEL = {ACC_IDX_REFSEL, 2'h0};
  localparam logic [9:0]  ACC_ADDR_IRQST  = {ACC_IDX_IRQST, 2'h0};
  localparam logic [9:0]  ACC_ADDR_IRQMSK = {ACC_IDX_IRQMSK, 2'h0};

  // ==========================================================================
  // field positions
  localparam int ACC_CTRL_EN     = 7;
  localparam int ACC_CTRL_RES    = 6;
  localparam int ACC_CTRL_SAMP   = 5;
  localparam int ACC_CTRL_INV    = 4;
  localparam int ACC_CTRL_MSEL_L = 1;
  localparam int ACC_CTRL_PSEL   = 0;
  localparam int ACC_RS_PINOE    = 7;
  localparam int ACC_RS_HI       = 5;
  localparam int ACC_RS_LO       = 4;
  localparam logic [7:0] ACC_CTRL_WMASK = 8'hBF;
  localparam logic [7:0] ACC_RS_WMASK   = 8'hBF;
  localparam logic [7:0] ACC_REG_RESET  = 8'h00;
  localparam logic [1:0] ACC_IRQ_RESET  = 2'h0;

  // ==========================================================================
  // minus input codes
  typedef enum logic [2:0] {
    ACC_MIN_PORT_A_PIN3 = 3'h0,
    ACC_MIN_PORT_A_PIN4 = 3'h1,
    ACC_MIN_BANDGP      = 3'h2,
    ACC_MIN_LADDER      = 3'h3,
    ACC_MIN_PORT_B_PIN6 = 3'h4,
    ACC_MIN_PORT_B_PIN7 = 3'h5
  } acc_minus_sel_t;

  // ladder ranges: {high, low} bits
  localparam logic [1:0] ACC_RNG_00 = 2'h0;
  localparam logic [1:0] ACC_RNG_01 = 2'h1;
  localparam logic [1:0] ACC_RNG_10 = 2'h2;
  localparam logic [1:0] ACC_RNG_11 = 2'h3;

  // ladder tap as fraction num/den of supply
  typedef struct packed {
    logic [5:0] num;
    logic [5:0] den;
  } acc_ladder_t;

  // comparator analog front end selection
  typedef struct packed {
    logic           enable;
    acc_minus_sel_t minus_sel;
    logic           plus_pin;
    acc_ladder_t    ladder;
  } acc_analog_cfg_t;

  // irq bits
  localparam int ACC_IRQ_RISE = 0;
  localparam int ACC_IRQ_FALL = 1;

  localparam logic [1:0] ACC_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] ACC_HSIZE_WORD    = 3'h2;
  localparam logic [31:0] ACC_ZERO32       = 32'h0;

endpackage

//--- hw/acc_ctrl.sv
// analog comparator control: registers, ladder code, result path and interrupt
// Operation
// - control bit 7 enables comparator, resets 0
// - control bit 6 reads result, read-only
// - bit 5 samples result on timer2 clock
// - bit 4 inverts comparator output polarity
// - bits 3..1 choose minus input source
// - bit 0 picks ladder or pin A4
// - select bit 7 drives result onto A0
// - select bits 5,4 set ladder range
// - select bits 3..0 are level code
// - level picks one of sixteen steps
// - range 00 gives 1/4 plus (n+1)/32
// - range 10 gives 1/5 plus (n+1)/40
// - pin A0 carries the final result, inverted only while bit 4 is set
// - result can raise an interrupt request
//
// The AHB-Lite slave port is this design's own decision.
module acc_ctrl
  import acc_pkg::*;
(
  // clock and reset
  input  wire logic                      hclk,
  input  wire logic                      hresetn,
  // ahb-lite slave
  input  wire logic                      hsel,
  input  wire logic [31:0]               haddr,
  input  wire logic [1:0]                htrans,
  input  wire logic                      hwrite,
  input  wire logic [2:0]                hsize,
  input  wire logic [31:0]               hwdata,
  input  wire logic                      hready,
  output logic      [31:0]               hrdata,
  output logic                           hreadyout,
  output logic                           hresp,
  // analog front end
  input  wire logic                      comp_raw,
  input  wire logic                      timer2_clock,
  output acc_pkg::acc_analog_cfg_t       analog_cfg,
  // pin A0 output path
  output logic                           port_a_pin0_out,
  output logic                           port_a_pin0_oe,
  // interrupt
  output logic                           irq
);
  import acc_pkg::*;

  // ==========================================================================
  // bus slave
  logic [7:0]  ctrl;
  logic [7:0]  refsel;
  logic [1:0]  irq_status;
  logic [1:0]  irq_mask;
  logic        wr_pend;
  logic [9:0]  wr_addr;
  logic        final_out;
  logic        t2_prev;
  logic        res_prev;
  logic [1:0]  evt;
  logic        addr_ok;
  logic [31:0] next_rdata;

  assign addr_ok = hsel && hready && (htrans == ACC_HTRANS_NONSEQ);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 10'h000;
    end else begin
      wr_pend <= addr_ok && hwrite && (haddr[31:10] == 22'h0);
      wr_addr <= haddr[9:0];
    end
  end

  always_comb begin
    next_rdata = ACC_ZERO32;
    case (haddr[9:0])
      ACC_ADDR_CTRL:   next_rdata = {24'h0, ctrl[7], final_out, ctrl[5:0]};
      ACC_ADDR_IRQST:  next_rdata = {30'h0, irq_status};
      ACC_ADDR_IRQMSK: next_rdata = {30'h0, irq_mask};
      default:         next_rdata = ACC_ZERO32;
    endcase
  end

  // zero-wait slave: reads answer in the data phase, refsel reads as zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= ACC_ZERO32;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (addr_ok && !hwrite && (haddr[31:10] == 22'h0)) begin
        hrdata <= next_rdata;
      end else begin
        hrdata <= ACC_ZERO32;
      end
    end
  end

  // ==========================================================================
  // control, reference select and interrupt mask registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= ACC_REG_RESET;
    end else if (wr_pend && wr_addr == ACC_ADDR_CTRL) begin
      ctrl <= hwdata[7:0] & ACC_CTRL_WMASK;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      refsel <= ACC_REG_RESET;
    end else if (wr_pend && wr_addr == ACC_ADDR_REFSEL) begin
      refsel <= hwdata[7:0] & ACC_RS_WMASK;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_mask <= ACC_IRQ_RESET;
    end else if (wr_pend && wr_addr == ACC_ADDR_IRQMSK) begin
      irq_mask <= hwdata[1:0];
    end
  end

  // ==========================================================================
  // ladder tap: offset and step give the fraction of supply
  function automatic acc_ladder_t ladder_tap(input logic [1:0] rng, input logic [3:0] n);
    acc_ladder_t t;
    logic [5:0]  step;
    t.num = 6'h00;
    t.den = 6'h00;
    step  = {2'h0, n} + 6'h01;
    case (rng)
      ACC_RNG_00: begin
        t.num = step + 6'h08;
        t.den = 6'h20;
      end
      ACC_RNG_01: begin
        t.num = step;
        t.den = 6'h18;
      end
      ACC_RNG_10: begin
        t.num = step + 6'h08;
        t.den = 6'h28;
      end
      ACC_RNG_11: begin
        t.num = step;
        t.den = 6'h20;
      end
      default: begin
        t.num = 6'h00;
      end
    endcase
    return t;
  endfunction

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      analog_cfg <= '0;
    end else begin
      analog_cfg.enable    <= ctrl[ACC_CTRL_EN];
      analog_cfg.minus_sel <= acc_minus_sel_t'(ctrl[3:ACC_CTRL_MSEL_L]);
      analog_cfg.plus_pin  <= ctrl[ACC_CTRL_PSEL];
      analog_cfg.ladder    <= ladder_tap(refsel[ACC_RS_HI:ACC_RS_LO], refsel[3:0]);
    end
  end

  // ==========================================================================
  // result path: invert first, then optional sampling on timer2 rising edges
  logic inv_out;
  assign inv_out = (comp_raw & ctrl[ACC_CTRL_EN]) ^ ctrl[ACC_CTRL_INV];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      t2_prev   <= 1'b0;
      final_out <= 1'b0;
    end else begin
      t2_prev <= timer2_clock;
      if (!ctrl[ACC_CTRL_SAMP]) begin
        final_out <= inv_out;
      end else if (timer2_clock && !t2_prev) begin
        final_out <= inv_out;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_a_pin0_out <= 1'b0;
      port_a_pin0_oe  <= 1'b0;
    end else begin
      port_a_pin0_out <= final_out & refsel[ACC_RS_PINOE];
      port_a_pin0_oe  <= refsel[ACC_RS_PINOE];
    end
  end

  // ==========================================================================
  // interrupt: edges of the final result, write one to clear, set wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      res_prev <= 1'b0;
    end else begin
      res_prev <= final_out;
    end
  end

  assign evt = {res_prev & ~final_out, ~res_prev & final_out};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status <= ACC_IRQ_RESET;
    end else if (wr_pend && wr_addr == ACC_ADDR_IRQST) begin
      irq_status <= (irq_status & ~hwdata[1:0]) | evt;
    end else begin
      irq_status <= irq_status | evt;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

  // ==========================================================================
  // checks
  property p_pin_follows;
    @(posedge hclk) disable iff (!hresetn)
      refsel[ACC_RS_PINOE] |=> (port_a_pin0_out == $past(final_out)) && port_a_pin0_oe;
  endproperty
  a_pin_follows: assert property (p_pin_follows) else $error("pin A0 does not follow result");

  property p_pin_off;
    @(posedge hclk) disable iff (!hresetn)
      !refsel[ACC_RS_PINOE] |=> !port_a_pin0_oe && !port_a_pin0_out;
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("pin A0 driven while disabled");

  property p_unsampled;
    @(posedge hclk) disable iff (!hresetn)
      !ctrl[ACC_CTRL_SAMP] |=> final_out == $past(inv_out);
  endproperty
  a_unsampled: assert property (p_unsampled) else $error("unsampled result wrong");

  property p_hold;
    @(posedge hclk) disable iff (!hresetn)
      ctrl[ACC_CTRL_SAMP] && !(timer2_clock && !t2_prev) |=> $stable(final_out);
  endproperty
  a_hold: assert property (p_hold) else $error("sampled result moved without timer2 edge");

  property p_inv;
    @(posedge hclk) disable iff (!hresetn)
      !ctrl[ACC_CTRL_SAMP] && ctrl[ACC_CTRL_INV] && ctrl[ACC_CTRL_EN]
        |=> final_out == !$past(comp_raw);
  endproperty
  a_inv: assert property (p_inv) else $error("inversion not applied");

  property p_irq_set;
    @(posedge hclk) disable iff (!hresetn)
      evt[ACC_IRQ_RISE] |=> irq_status[ACC_IRQ_RISE];
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("rise event lost");

  property p_irq_out;
    @(posedge hclk) disable iff (!hresetn)
      |(irq_status & irq_mask) |=> irq;
  endproperty
  a_irq_out: assert property (p_irq_out) else $error("irq not raised");

  property p_en_cfg;
    @(posedge hclk) disable iff (!hresetn)
      1'b1 |=> analog_cfg.enable == $past(ctrl[ACC_CTRL_EN]) &&
               analog_cfg.plus_pin == $past(ctrl[ACC_CTRL_PSEL]);
  endproperty
  a_en_cfg: assert property (p_en_cfg) else $error("analog config mismatch");

  property p_ladder00;
    @(posedge hclk) disable iff (!hresetn)
      refsel[5:4] == ACC_RNG_00 |=> analog_cfg.ladder.den == 6'h20 &&
        analog_cfg.ladder.num == {2'h0, $past(refsel[3:0])} + 6'h09;
  endproperty
  a_ladder00: assert property (p_ladder00) else $error("ladder range 00 wrong");

  property p_ladder10;
    @(posedge hclk) disable iff (!hresetn)
      refsel[5:4] == ACC_RNG_10 |=> analog_cfg.ladder.den == 6'h28 &&
        analog_cfg.ladder.num == {2'h0, $past(refsel[3:0])} + 6'h09;
  endproperty
  a_ladder10: assert property (p_ladder10) else $error("ladder range 10 wrong");

  property p_ladder01;
    @(posedge hclk) disable iff (!hresetn)
      refsel[5:4] == ACC_RNG_01 |=> analog_cfg.ladder.den == 6'h18 &&
        analog_cfg.ladder.num == {2'h0, $past(refsel[3:0])} + 6'h01;
  endproperty
  a_ladder01: assert property (p_ladder01) else $error("ladder range 01 wrong");

  property p_ladder11;
    @(posedge hclk) disable iff (!hresetn)
      refsel[5:4] == ACC_RNG_11 |=> analog_cfg.ladder.den == 6'h20 &&
        analog_cfg.ladder.num == {2'h0, $past(refsel[3:0])} + 6'h01;
  endproperty
  a_ladder11: assert property (p_ladder11) else $error("ladder range 11 wrong");

  property p_minus_sel;
    @(posedge hclk) disable iff (!hresetn)
      1'b1 |=> analog_cfg.minus_sel == $past(ctrl[3:ACC_CTRL_MSEL_L]);
  endproperty
  a_minus_sel: assert property (p_minus_sel) else $error("minus select not passed on");

  property p_sample_edge;
    @(posedge hclk) disable iff (!hresetn)
      ctrl[ACC_CTRL_SAMP] && timer2_clock && !t2_prev |=> final_out == $past(inv_out);
  endproperty
  a_sample_edge: assert property (p_sample_edge) else $error("timer2 edge did not sample result");

  property p_inv_off;
    @(posedge hclk) disable iff (!hresetn)
      !ctrl[ACC_CTRL_SAMP] && !ctrl[ACC_CTRL_INV] && ctrl[ACC_CTRL_EN]
        |=> final_out == $past(comp_raw);
  endproperty
  a_inv_off: assert property (p_inv_off) else $error("result inverted while inversion is off");

  // the pin stage adds one cycle behind the result register
  property p_pin_inv;
    @(posedge hclk) disable iff (!hresetn)
      refsel[ACC_RS_PINOE] && ctrl[ACC_CTRL_INV] && ctrl[ACC_CTRL_EN] && !ctrl[ACC_CTRL_SAMP]
        ##1 refsel[ACC_RS_PINOE] |=> port_a_pin0_out == !$past(comp_raw, 2);
  endproperty
  a_pin_inv: assert property (p_pin_inv) else $error("pin A0 does not carry inverted result");

  property p_rd_result;
    @(posedge hclk) disable iff (!hresetn)
      addr_ok && !hwrite && haddr == {22'h0, ACC_ADDR_CTRL} |=> hrdata[ACC_CTRL_RES] == $past(final_out);
  endproperty
  a_rd_result: assert property (p_rd_result) else $error("result bit reads wrong");

  property p_rd_refsel;
    @(posedge hclk) disable iff (!hresetn)
      addr_ok && !hwrite && haddr == {22'h0, ACC_ADDR_REFSEL} |=> hrdata == ACC_ZERO32;
  endproperty
  a_rd_refsel: assert property (p_rd_refsel) else $error("write-only select register readable");

  property p_rd_irqst;
    @(posedge hclk) disable iff (!hresetn)
      addr_ok && !hwrite && haddr == {22'h0, ACC_ADDR_IRQST} |=> hrdata[1:0] == $past(irq_status);
  endproperty
  a_rd_irqst: assert property (p_rd_irqst) else $error("status reads wrong");

  property p_irq_low;
    @(posedge hclk) disable iff (!hresetn)
      !(|(irq_status & irq_mask)) |=> !irq;
  endproperty
  a_irq_low: assert property (p_irq_low) else $error("irq raised with nothing pending");

  property p_irq_fall;
    @(posedge hclk) disable iff (!hresetn)
      evt[ACC_IRQ_FALL] |=> irq_status[ACC_IRQ_FALL];
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("fall event lost");

  property p_irq_clear;
    @(posedge hclk) disable iff (!hresetn)
      wr_pend && wr_addr == ACC_ADDR_IRQST && hwdata[ACC_IRQ_RISE] && !evt[ACC_IRQ_RISE]
        |=> !irq_status[ACC_IRQ_RISE];
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("rise status not cleared");

  c_pin_on:  cover property (@(posedge hclk) disable iff (!hresetn) port_a_pin0_oe && port_a_pin0_out);
  c_inv_pin: cover property (@(posedge hclk) disable iff (!hresetn) port_a_pin0_oe && ctrl[ACC_CTRL_INV]);
  c_irq:     cover property (@(posedge hclk) disable iff (!hresetn) irq);
  c_sampled: cover property (@(posedge hclk) disable iff (!hresetn)
                            ctrl[ACC_CTRL_SAMP] && timer2_clock && !t2_prev);
endmodule

//--- tb/acc_analog_model.sv
// far side model: analog pins, bandgap and resistor ladder feeding the comparator
module acc_analog_model
  import acc_pkg::*;
#(
  parameter int VDD_MV     = 5000,
  parameter int BANDGAP_MV = 1200
)
(
  // selection from the block
  input  acc_pkg::acc_analog_cfg_t cfg,
  // pin levels in millivolts: A3, A4, B6, B7
  input  int                       pin_mv [4],
  // digital input buffers of the same pins, 1 while on
  input  logic [3:0]               din_en,
  // comparator decision
  output logic                     comp_raw,
  // a pin in use by the comparator still has its digital input on
  output logic                     leak
);
  import acc_pkg::*;
  int ref_mv;
  int minus_mv;
  int plus_mv;
  // ==========================================================================
  // comparator
  always_comb begin
    // an unprogrammed divider reads as ground rather than dividing by zero
    ref_mv = (cfg.ladder.den == 6'h00) ? 0 : int'(cfg.ladder.num) * VDD_MV / int'(cfg.ladder.den);
    case (cfg.minus_sel)
      ACC_MIN_PORT_A_PIN3: minus_mv = pin_mv[0];
      ACC_MIN_PORT_A_PIN4: minus_mv = pin_mv[1];
      ACC_MIN_BANDGP:      minus_mv = BANDGAP_MV;
      ACC_MIN_LADDER:      minus_mv = ref_mv;
      ACC_MIN_PORT_B_PIN6: minus_mv = pin_mv[2];
      ACC_MIN_PORT_B_PIN7: minus_mv = pin_mv[3];
      // reserved codes tie to supply so the result stays low
      default:             minus_mv = VDD_MV;
    endcase
    plus_mv = cfg.plus_pin ? pin_mv[1] : ref_mv;
    comp_raw = (plus_mv > minus_mv);
    // an analog level on a pin with its digital buffer on draws leakage
    leak = cfg.enable && ((din_en[0] && cfg.minus_sel == ACC_MIN_PORT_A_PIN3) ||
                          (din_en[1] && (cfg.minus_sel == ACC_MIN_PORT_A_PIN4 || cfg.plus_pin)) ||
                          (din_en[2] && cfg.minus_sel == ACC_MIN_PORT_B_PIN6) ||
                          (din_en[3] && cfg.minus_sel == ACC_MIN_PORT_B_PIN7));
  end
endmodule

//--- tb/analog_comparator_control_test.sv
// register-level bench for the analog comparator control block
module analog_comparator_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  import acc_pkg::*;
  localparam int VDD_MV = 5000;
  logic            hclk, hresetn, hsel, hwrite, timer2_clock;
  logic [31:0]     haddr, hwdata, hrdata, rd;
  logic [1:0]      htrans;
  logic [2:0]      hsize;
  logic            hreadyout, hresp, comp_raw, pin0_out, pin0_oe, irq, leak;
  logic [3:0]      din_en;
  acc_analog_cfg_t cfg;
  int              pin_mv [4];
  int              n_fail = 0;
  int              n_checks = 0;
  int              flip, flip_exp;

  acc_ctrl dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .comp_raw(comp_raw), .timer2_clock(timer2_clock),
    .analog_cfg(cfg), .port_a_pin0_out(pin0_out), .port_a_pin0_oe(pin0_oe), .irq(irq));
  acc_analog_model #(.VDD_MV(VDD_MV), .BANDGAP_MV(1200)) far (.cfg(cfg), .pin_mv(pin_mv), .din_en(din_en),
    .comp_raw(comp_raw), .leak(leak));

  // ==========================================================================
  // tasks
  task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {22'h000000, a};
    htrans <= ACC_HTRANS_NONSEQ;
    hwrite <= wr;
    hsize <= ACC_HSIZE_WORD;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  function automatic acc_ladder_t lad(input int r, input int n);
    case (r)
      0:       return '{6'(n + 9), 6'h20};
      1:       return '{6'(n + 1), 6'h18};
      2:       return '{6'(n + 9), 6'h28};
      default: return '{6'(n + 1), 6'h20};
    endcase
  endfunction

  // ==========================================================================
  // clock and watchdog
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  initial begin
    #200000;
    n_fail++;
    results();
  end

  // ==========================================================================
  // tests
  initial begin
    hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
    hsize = 3'h0; hwdata = 32'h0; timer2_clock = 1'b0;
    pin_mv = '{1000, 1000, 1000, 1000};
    din_en = 4'hF;
    tick(20);
    hresetn <= 1'b1;
    tick(2);
    chk("pin oe", 32'h0, 32'(pin0_oe));
    chk("cfg", 32'h0, 32'({cfg.enable, cfg.minus_sel, cfg.plus_pin}));
    chk("ladder", 32'(lad(0, 0)), 32'(cfg.ladder));
    bus(1'b0, ACC_ADDR_CTRL, 32'h0); chk("ctrl", 32'h0, rd);
    bus(1'b0, ACC_ADDR_REFSEL, 32'h0); chk("refsel", 32'h0, rd);
    chk("hresp", 32'h0, 32'(hresp));
    bus(1'b1, 10'h070, 32'hFF); bus(1'b0, 10'h070, 32'h0); chk("unmapped", 32'h0, rd);
    for (int r = 0; r < 4; r++) begin
      for (int n = 0; n < 16; n += 15) begin
        bus(1'b1, ACC_ADDR_REFSEL, 32'({r[1:0], n[3:0]}));
        tick(2);
        chk("ladder", 32'(lad(r, n)), 32'(cfg.ladder));
      end
    end
    for (int c = 0; c < 8; c++) begin
      bus(1'b1, ACC_ADDR_CTRL, 32'({1'b1, 3'h0, c[2:0], c[0]}));
      tick(2);
      chk("sel", 32'({1'b1, c[2:0], c[0]}), 32'({cfg.enable, cfg.minus_sel, cfg.plus_pin}));
      bus(1'b0, ACC_ADDR_CTRL, 32'h0); chk("ctrl rb", 32'({1'b1, 3'h0, c[2:0], c[0]}), rd & 32'hBF);
    end
    // A3 as minus, ladder 18/32 as plus, A3 digital input switched off first
    din_en <= 4'hE;
    bus(1'b1, ACC_ADDR_REFSEL, 32'h09);
    bus(1'b1, ACC_ADDR_CTRL, 32'h80); tick(3);
    chk("leak", 32'h0, 32'(leak));
    bus(1'b0, ACC_ADDR_CTRL, 32'h0); chk("result", 32'hC0, rd);
    bus(1'b1, ACC_ADDR_CTRL, 32'h90); tick(3);
    bus(1'b0, ACC_ADDR_CTRL, 32'h0); chk("inverted", 32'h90, rd);
    bus(1'b1, ACC_ADDR_REFSEL, 32'h89); tick(3);
    chk("pin", 32'h2, 32'({pin0_oe, pin0_out}));
    pin_mv[0] <= 4000; tick(4);
    chk("pin", 32'h3, 32'({pin0_oe, pin0_out}));
    // sampled mode: result moves only on a timer-2 rising edge
    bus(1'b1, ACC_ADDR_CTRL, 32'hA0); tick(4);
    bus(1'b0, ACC_ADDR_CTRL, 32'h0); chk("held", 32'hE0, rd);
    timer2_clock <= 1'b1; tick(2); timer2_clock <= 1'b0; tick(3);
    bus(1'b0, ACC_ADDR_CTRL, 32'h0); chk("sampled", 32'hA0, rd);
    chk("pin", 32'h2, 32'({pin0_oe, pin0_out}));
    // interrupt on rising result
    bus(1'b1, ACC_ADDR_CTRL, 32'h80); tick(3);
    bus(1'b0, ACC_ADDR_IRQST, 32'h0); chk("status both", 32'h3, rd);
    bus(1'b1, ACC_ADDR_IRQST, 32'h3); bus(1'b1, ACC_ADDR_IRQMSK, 32'h1); tick(3);
    chk("irq", 32'h0, 32'(irq));
    pin_mv[0] <= 1000; tick(4);
    chk("irq", 32'h1, 32'(irq));
    bus(1'b0, ACC_ADDR_IRQST, 32'h0); chk("status", 32'h1, rd);
    bus(1'b1, ACC_ADDR_IRQMSK, 32'h0); tick(3); chk("irq", 32'h0, 32'(irq));
    bus(1'b1, ACC_ADDR_IRQMSK, 32'h1); tick(3); chk("irq", 32'h1, 32'(irq));
    bus(1'b1, ACC_ADDR_IRQST, 32'h1); tick(3); chk("irq", 32'h0, 32'(irq));
    // supply measurement: bandgap minus, ladder plus, step the level
    flip = -1;
    flip_exp = -1;
    for (int n = 15; n >= 0; n--) begin
      if ((n + 1) * VDD_MV > 1200 * 24) flip_exp = n;
    end
    bus(1'b1, ACC_ADDR_CTRL, 32'h84);
    for (int n = 0; n < 16; n++) begin
      bus(1'b1, ACC_ADDR_REFSEL, 32'({4'h1, n[3:0]}));
      tick(4);
      bus(1'b0, ACC_ADDR_CTRL, 32'h0);
      if (rd[6] === 1'b1 && flip < 0) flip = n;
    end
    chk("flip", 32'(flip_exp), 32'(flip));
    // mid-run reset must bring pin A0, irq, ladder and control register back to their reset values
    bus(1'b1, ACC_ADDR_REFSEL, 32'h9F); tick(3);
    chk("pin oe", 32'h1, 32'(pin0_oe));
    hresetn <= 1'b0;
    tick(2);
    hresetn <= 1'b1;
    tick(2);
    chk("reset pin", 32'h0, 32'({pin0_oe, pin0_out}));
    chk("reset irq", 32'h0, 32'(irq));
    chk("reset ladder", 32'(lad(0, 0)), 32'(cfg.ladder));
    bus(1'b0, ACC_ADDR_CTRL, 32'h0); chk("reset ctrl", 32'h0, rd);
    results();
  end
endmodule
